// >>> hdl/dpcb_param_bank.sv
// Drive parameter bank: warnings, access control, brake, capture unit 1 and user memory.
//
// Summary of operation
// - Fault reset clears latched warning bits whose condition is no longer active.
// - Warning bits 10, 11, 13 self-clear.
// - Fixed warning bit map, bits 3, 15 reserved.
// - Active warnings readable with same layout.
// - Report signed bus voltage utilisation percentage.
// - Absolute moves need homing when enabled.
// - Writing 1 claims, 0 releases exclusive access.
// - Exclusive read shows whether channel holds it.
// - Lock blocks input and commissioning control.
// - Halt input is always processed.
// - Manual brake release only when disabled/ready.
// - Power stage enable forces release to 0.
// - Brake status: applied, released, absent.
// - Activation code: stop, once, continuous.
// - Single capture stops after first value.
// - Edge select: 0 falling, 1 rising.
// - 16-bit event counter, cleared on activation.
// - Store captured position, adjust on re-referencing.
// - Two 32-bit user memory words, reset to USER_MEM_RESET.
// - Capture status bit 0 set on capture.
`timescale 1ns/10ps
module dpcb_param_bank
	import dpcb_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic paramReq,
	input wire logic paramWrite,
	input wire logic [15:0] paramAddr,
	input wire logic [31:0] paramWdata,
	input wire logic [1:0] paramChannel,
	output logic paramAck,
	output logic paramError,
	output logic [31:0] paramRdata,
	input wire logic [15:0] warnConditions,
	input wire logic faultReset,
	input wire logic signed [15:0] voltUtilIn,
	input wire logic homingDone,
	input wire logic absMoveRequest,
	output logic absMoveAllowed,
	output logic inputControlEnable,
	output logic commissioningEnable,
	input wire logic haltPin,
	output logic haltActive,
	input wire logic [3:0] opState,
	input wire logic powerStageEnabled,
	input wire logic brakeFitted,
	input wire logic brakeOpen,
	output logic brakeReleaseCmd,
	input wire logic capturePin,
	input wire logic signed [31:0] actualPosition,
	input wire logic positionAdjust,
	input wire logic signed [31:0] positionDelta,
	output logic captureOneCaptured
);
	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] rdata;
		logic exclHeld;
		logic [1:0] exclOwner;
		logic lock;
		logic [31:0] userMem3;
		logic [31:0] userMem4;
		logic absHome;
		logic brakeRel;
		logic brakeCmd;
		logic [1:0] brakeState;
		logic absAllowed;
		logic inEnable;
		logic commEnable;
		logic capEdge;
		dpcb_capmode_type capMode;
		logic signed [31:0] capPos;
		logic [15:0] capCount;
		logic capStat;
		logic [15:0] active_warning_bits;
		logic [15:0] latched_warning_bits;
		logic [15:0] bus_voltage_utilisation;
		logic [2:0] capSync;
		logic capLevel;
		logic [2:0] haltSync;
		logic haltLevel;
	} dpcb_state_type;

	dpcb_state_type s_q;
	dpcb_state_type s_d;
	logic capEvent;
	logic refused;
	logic outOfRange;
	logic [15:0] actWarn;
	logic brakeWindow;

	always_comb begin
		s_d = s_q;
		s_d.ack = 1'b0;
		s_d.err = 1'b0;
		refused = 1'b0;
		outOfRange = 1'b0;

		// Pins are asynchronous; a level counts once the second and third stages agree.
		s_d.capSync = {s_q.capSync[1:0], capturePin};
		if (s_q.capSync[1] == s_q.capSync[2]) begin
			s_d.capLevel = s_q.capSync[2];
		end
		s_d.haltSync = {s_q.haltSync[1:0], haltPin};
		if (s_q.haltSync[1] == s_q.haltSync[2]) begin
			s_d.haltLevel = s_q.haltSync[2];
		end
		capEvent = (s_d.capLevel != s_q.capLevel) && (s_d.capLevel == s_q.capEdge);

		actWarn = warnConditions & ~WARN_RESERVED_MASK;
		s_d.active_warning_bits = actWarn;
		// A condition present during the fault reset stays latched: the set wins.
		if (faultReset) begin
			s_d.latched_warning_bits = actWarn;
		end else begin
			s_d.latched_warning_bits = (s_q.latched_warning_bits & ~WARN_AUTOCLEAR_MASK) | actWarn;
		end
		s_d.bus_voltage_utilisation = voltUtilIn;

		if (positionAdjust) begin
			s_d.capPos = s_q.capPos + positionDelta;
		end
		if (capEvent && s_q.capMode != CAP_IDLE) begin
			s_d.capPos = actualPosition;
			s_d.capCount = s_q.capCount + 16'h0001;
			s_d.capStat = 1'b1;
			if (s_q.capMode == CAP_SINGLE) begin
				s_d.capMode = CAP_IDLE;
			end
		end

		if (paramReq) begin
			s_d.ack = 1'b1;
			s_d.rdata = 32'h0000_0000;
			case (paramAddr)
				ADDR_EXCLUSIVE: begin
					s_d.rdata[0] = s_q.exclHeld && (s_q.exclOwner == paramChannel);
				end
				ADDR_LOCK: s_d.rdata[0] = s_q.lock;
				ADDR_USER_MEM3: s_d.rdata = s_q.userMem3;
				ADDR_USER_MEM4: s_d.rdata = s_q.userMem4;
				ADDR_ABS_HOME: s_d.rdata[0] = s_q.absHome;
				ADDR_BRAKE_REL: s_d.rdata[0] = s_q.brakeRel;
				ADDR_BRAKE_STATE: s_d.rdata[1:0] = s_q.brakeState;
				ADDR_CAPTURE_INPUT_ONE_EDGE: s_d.rdata[0] = s_q.capEdge;
				ADDR_CAPTURE_INPUT_ONE_ACT: begin
					case (s_q.capMode)
						CAP_SINGLE: s_d.rdata = ACT_ONCE;
						CAP_CONTINUOUS: s_d.rdata = ACT_CONTINUOUS;
						default: s_d.rdata = ACT_STOP;
					endcase
				end
				ADDR_CAPTURE_INPUT_ONE_POS: s_d.rdata = s_q.capPos;
				ADDR_CAPTURE_INPUT_ONE_COUNT: s_d.rdata[15:0] = s_q.capCount;
				ADDR_WARN_ACTIVE: s_d.rdata[15:0] = s_q.active_warning_bits;
				ADDR_WARN_LATCHED: s_d.rdata[15:0] = s_q.latched_warning_bits;
				ADDR_VOLT_UTIL: s_d.rdata[15:0] = s_q.bus_voltage_utilisation;
				default: s_d.err = 1'b1;
			endcase

			if (paramWrite) begin
				s_d.rdata = 32'h0000_0000;
				// A foreign channel may not write while another holds exclusive access.
				refused = s_q.exclHeld && (s_q.exclOwner != paramChannel);
				if (s_q.lock && paramChannel == CH_COMMISSIONING) begin
					refused = 1'b1;
				end
				case (paramAddr)
					ADDR_USER_MEM3, ADDR_USER_MEM4: outOfRange = 1'b0;
					ADDR_CAPTURE_INPUT_ONE_ACT: outOfRange = paramWdata > MAX_ACTIVATION;
					ADDR_EXCLUSIVE, ADDR_LOCK, ADDR_ABS_HOME, ADDR_BRAKE_REL,
					ADDR_CAPTURE_INPUT_ONE_EDGE: outOfRange = paramWdata > MAX_FLAG;
					default: refused = 1'b1;
				endcase
				s_d.err = refused || outOfRange;
				if (!refused && !outOfRange) begin
					case (paramAddr)
						ADDR_EXCLUSIVE: begin
							s_d.exclHeld = paramWdata[0];
							s_d.exclOwner = paramChannel;
						end
						ADDR_LOCK: s_d.lock = paramWdata[0];
						ADDR_USER_MEM3: s_d.userMem3 = paramWdata;
						ADDR_USER_MEM4: s_d.userMem4 = paramWdata;
						ADDR_ABS_HOME: s_d.absHome = paramWdata[0];
						ADDR_BRAKE_REL: s_d.brakeRel = paramWdata[0];
						ADDR_CAPTURE_INPUT_ONE_EDGE: s_d.capEdge = paramWdata[0];
						ADDR_CAPTURE_INPUT_ONE_ACT: begin
							if (paramWdata == ACT_ONCE) begin
								s_d.capMode = CAP_SINGLE;
							end else if (paramWdata == ACT_CONTINUOUS) begin
								s_d.capMode = CAP_CONTINUOUS;
							end else begin
								s_d.capMode = CAP_IDLE;
							end
							if (paramWdata != ACT_STOP) begin
								s_d.capCount = 16'h0000;
								s_d.capStat = 1'b0;
							end
						end
						default: s_d.err = 1'b1;
					endcase
				end
			end
		end

		// Enabling the power stage overrides any write in the same cycle.
		if (powerStageEnabled) begin
			s_d.brakeRel = 1'b0;
		end
		brakeWindow = (opState == OPSTATE_SWITCH_ON_DISABLED) ||
			(opState == OPSTATE_READY_TO_SWITCH_ON);
		s_d.brakeCmd = s_q.brakeRel && brakeWindow && !powerStageEnabled;
		if (!brakeFitted) begin
			s_d.brakeState = BRAKE_ABSENT;
		end else if (brakeOpen) begin
			s_d.brakeState = BRAKE_RELEASED;
		end else begin
			s_d.brakeState = BRAKE_APPLIED;
		end
		s_d.absAllowed = absMoveRequest && (!s_q.absHome || homingDone);
		s_d.inEnable = !s_q.lock;
		s_d.commEnable = !s_q.lock;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s_q <= '0;
			s_q.capMode <= CAP_IDLE;
			s_q.userMem3 <= USER_MEM_RESET;
			s_q.userMem4 <= USER_MEM_RESET;
			s_q.inEnable <= 1'b1;
			s_q.commEnable <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign paramAck = s_q.ack;
	assign paramError = s_q.err;
	assign paramRdata = s_q.rdata;
	assign absMoveAllowed = s_q.absAllowed;
	assign inputControlEnable = s_q.inEnable;
	assign commissioningEnable = s_q.commEnable;
	assign haltActive = s_q.haltLevel;
	assign brakeReleaseCmd = s_q.brakeCmd;
	assign captureOneCaptured = s_q.capStat;

	default clocking dpcbClk @(posedge clock);
	endclocking
	default disable iff (reset);

	// A write that neither exclusivity nor the lock refuses; the range is checked per address.
	logic writeAllowed;
	assign writeAllowed = paramReq && paramWrite &&
		!(s_q.exclHeld && (s_q.exclOwner != paramChannel)) &&
		!(s_q.lock && (paramChannel == CH_COMMISSIONING));

	sequence haltHeld;
		haltPin[*4];
	endsequence

	sequence haltDropped;
		!haltPin[*4];
	endsequence

	sequence singleCapture;
		(s_q.capMode == CAP_SINGLE) && capEvent && !(paramReq && paramWrite);
	endsequence

	sequence captureTaken;
		capEvent && (s_q.capMode != CAP_IDLE);
	endsequence

	fault_reset_clear_a: assert property (
		faultReset |=> s_q.latched_warning_bits == s_q.active_warning_bits)
		else $error("Latched warnings not cleared by fault reset.");
	latched_set_a: assert property (
		##1 (s_q.latched_warning_bits & s_q.active_warning_bits) == s_q.active_warning_bits)
		else $error("Active warning missing from latched word.");
	auto_clear_bits_a: assert property (
		##1 ((s_q.latched_warning_bits ^ s_q.active_warning_bits) & WARN_AUTOCLEAR_MASK) == 16'h0000)
		else $error("Self-clearing warning bit disagrees with condition.");
	reserved_warn_zero_a: assert property (
		((s_q.latched_warning_bits | s_q.active_warning_bits) & WARN_RESERVED_MASK) == 16'h0000)
		else $error("Reserved warning bit set.");
	active_map_a: assert property (
		##1 s_q.active_warning_bits == $past(warnConditions & ~WARN_RESERVED_MASK))
		else $error("Active warning word does not follow conditions.");
	volt_follow_a: assert property (##1 s_q.bus_voltage_utilisation == $past(voltUtilIn))
		else $error("Voltage utilisation readout stale.");
	abs_gate_a: assert property (
		absMoveAllowed |-> $past(absMoveRequest) && (!$past(s_q.absHome) || $past(homingDone)))
		else $error("Absolute move allowed before homing.");
	excl_claim_a: assert property (
		writeAllowed && paramAddr == ADDR_EXCLUSIVE && paramWdata <= MAX_FLAG
		|=> s_q.exclHeld == $past(paramWdata[0]))
		else $error("Exclusive access claim or release lost.");
	excl_foreign_a: assert property (
		paramReq && paramWrite && s_q.exclHeld && s_q.exclOwner != paramChannel |=> paramError)
		else $error("Foreign channel wrote during exclusive access.");
	excl_readback_a: assert property (
		paramReq && !paramWrite && paramAddr == ADDR_EXCLUSIVE
		|=> paramRdata == {31'h0, $past(s_q.exclHeld && s_q.exclOwner == paramChannel)})
		else $error("Exclusive access readback wrong.");
	lock_refuse_a: assert property (
		paramReq && paramWrite && s_q.lock && paramChannel == CH_COMMISSIONING
		|=> paramError && paramAck)
		else $error("Locked commissioning write was accepted.");
	lock_enables_a: assert property (
		##1 inputControlEnable == !$past(s_q.lock) && commissioningEnable == !$past(s_q.lock))
		else $error("Control enables disagree with lock.");
	halt_passes_a: assert property (haltHeld |-> ##1 haltActive)
		else $error("Held halt pin not seen within four cycles.");
	halt_drops_a: assert property (haltDropped |-> ##1 !haltActive)
		else $error("Released halt pin still seen after four cycles.");
	brake_window_a: assert property (
		brakeReleaseCmd |-> $past(brakeWindow) && $past(s_q.brakeRel))
		else $error("Brake released outside permitted states.");
	brake_outside_a: assert property (!brakeWindow |=> !brakeReleaseCmd)
		else $error("Brake command outside permitted states.");
	brake_force_zero_a: assert property (
		powerStageEnabled |=> !s_q.brakeRel ##1 !brakeReleaseCmd)
		else $error("Manual brake release survived power stage enable.");
	brake_state_a: assert property (
		##1 s_q.brakeState == (!$past(brakeFitted) ? BRAKE_ABSENT :
		($past(brakeOpen) ? BRAKE_RELEASED : BRAKE_APPLIED)))
		else $error("Brake status code wrong.");
	state_readonly_a: assert property (
		paramReq && paramWrite && paramAddr == ADDR_BRAKE_STATE |=> paramError)
		else $error("Write to brake status accepted.");
	stop_cancel_a: assert property (
		writeAllowed && paramAddr == ADDR_CAPTURE_INPUT_ONE_ACT && paramWdata == ACT_STOP
		|=> s_q.capMode == CAP_IDLE)
		else $error("Capture stop did not cancel capture.");
	single_stop_a: assert property (
		singleCapture |=> s_q.capMode == CAP_IDLE &&
		s_q.capCount == $past(s_q.capCount) + 16'h0001 && captureOneCaptured)
		else $error("Single capture did not stop and count.");
	continuous_keep_a: assert property (
		s_q.capMode == CAP_CONTINUOUS && !(paramReq && paramWrite)
		|=> s_q.capMode == CAP_CONTINUOUS)
		else $error("Continuous capture stopped by itself.");
	activation_clear_a: assert property (
		paramReq && paramWrite && paramAddr == ADDR_CAPTURE_INPUT_ONE_ACT && paramWdata == ACT_ONCE &&
		!paramError && s_q.exclHeld == 1'b0 && !(s_q.lock && paramChannel == CH_COMMISSIONING)
		|=> s_q.capCount == 16'h0000 && paramAck)
		else $error("Event counter not cleared on activation.");
	capture_pos_a: assert property (captureTaken |=> s_q.capPos == $past(actualPosition))
		else $error("Captured position not stored.");
	position_adjust_a: assert property (
		positionAdjust && !(capEvent && s_q.capMode != CAP_IDLE)
		|=> s_q.capPos == $past(s_q.capPos) + $past(positionDelta))
		else $error("Captured position not recomputed.");
	user_mem_write_a: assert property (
		writeAllowed && paramAddr == ADDR_USER_MEM3 |=> s_q.userMem3 == $past(paramWdata))
		else $error("User memory write lost.");
	status_set_a: assert property (captureTaken |=> captureOneCaptured)
		else $error("Capture status bit not set.");
	range_reject_a: assert property (
		paramReq && paramWrite && paramAddr == ADDR_CAPTURE_INPUT_ONE_ACT && paramWdata > MAX_ACTIVATION
		&& !capEvent |=> paramError && $stable(s_q.capMode))
		else $error("Out-of-range activation accepted.");
endmodule : dpcb_param_bank

// >>> hdl/dpcb_pkg.sv
// Constants, parameter addresses and field layouts of the drive parameter capture bank.
package dpcb_pkg;
	// Parameter addresses as seen by the fieldbus.
	localparam logic [15:0] ADDR_EXCLUSIVE = 16'h011A;
	localparam logic [15:0] ADDR_LOCK = 16'h013C;
	localparam logic [15:0] ADDR_USER_MEM3 = 16'h0142;
	localparam logic [15:0] ADDR_USER_MEM4 = 16'h0144;
	localparam logic [15:0] ADDR_ABS_HOME = 16'h062C;
	localparam logic [15:0] ADDR_BRAKE_REL = 16'h0814;
	localparam logic [15:0] ADDR_BRAKE_STATE = 16'h0816;
	localparam logic [15:0] ADDR_CAPTURE_INPUT_ONE_EDGE = 16'h0A04;
	localparam logic [15:0] ADDR_CAPTURE_INPUT_ONE_ACT = 16'h0A08;
	localparam logic [15:0] ADDR_CAPTURE_INPUT_ONE_POS = 16'h0A0C;
	localparam logic [15:0] ADDR_CAPTURE_INPUT_ONE_COUNT = 16'h0A10;
	localparam logic [15:0] ADDR_WARN_ACTIVE = 16'h1C16;
	localparam logic [15:0] ADDR_WARN_LATCHED = 16'h1C18;
	localparam logic [15:0] ADDR_VOLT_UTIL = 16'h1E26;

	// Warning word layout.
	localparam int WARN_GENERAL = 0;
	localparam int WARN_STAGE_HOT = 1;
	localparam int WARN_MOTOR_HOT = 2;
	localparam int WARN_STAGE_OVL = 4;
	localparam int WARN_MOTOR_OVL = 5;
	localparam int WARN_RESISTOR_OVL = 6;
	localparam int WARN_CAN = 7;
	localparam int WARN_ENCODER = 8;
	localparam int WARN_RS485 = 9;
	localparam int WARN_SAFE_TORQUE_OFF = 10;
	localparam int WARN_UNDERVOLTAGE = 11;
	localparam int WARN_PROCESS_BUS = 12;
	localparam int WARN_POS_INVALID = 13;
	localparam int WARN_ETHERNET = 14;
	localparam logic [15:0] WARN_RESERVED_MASK = 16'h8008;
	localparam logic [15:0] WARN_AUTOCLEAR_MASK = 16'h2C00;

	// Field values.
	localparam logic [31:0] USER_MEM_RESET = 32'h0000_0000;
	localparam logic [31:0] MAX_FLAG = 32'h0000_0001;
	localparam logic [31:0] MAX_ACTIVATION = 32'h0000_0002;
	localparam logic [31:0] ACT_STOP = 32'h0000_0000;
	localparam logic [31:0] ACT_ONCE = 32'h0000_0001;
	localparam logic [31:0] ACT_CONTINUOUS = 32'h0000_0002;
	localparam logic [1:0] BRAKE_APPLIED = 2'h0;
	localparam logic [1:0] BRAKE_RELEASED = 2'h1;
	localparam logic [1:0] BRAKE_ABSENT = 2'h2;

	// Access channels and operating state codes.
	localparam logic [1:0] CH_FIELDBUS = 2'h0;
	localparam logic [1:0] CH_COMMISSIONING = 2'h1;
	localparam logic [3:0] OPSTATE_SWITCH_ON_DISABLED = 4'h3;
	localparam logic [3:0] OPSTATE_READY_TO_SWITCH_ON = 4'h4;

	typedef enum logic [1:0] {CAP_IDLE, CAP_SINGLE, CAP_CONTINUOUS} dpcb_capmode_type;
endpackage : dpcb_pkg

// >>> verif/dpcb_drive_model.sv
// Plant side model of the holding brake driven by the bank's release command.
`timescale 1ns/10ps
module dpcb_drive_model (
	input wire logic clock,
	input wire logic brakeReleaseCmd,
	output logic brakeOpen
);
	// The brake takes one cycle to move, so the status never follows the command at once.
	always_ff @(posedge clock) begin
		brakeOpen <= brakeReleaseCmd;
	end
endmodule : dpcb_drive_model

// >>> verif/tb_top.sv
// Testbench of the drive parameter bank driven through its parameter port.
`timescale 1ns/10ps
module tb_top
	import dpcb_pkg::*;
;
	logic clock = '0, reset = 1'h1, paramReq = '0, paramWrite = '0, faultReset = '0;
	logic [15:0] paramAddr = '0, warnConditions = '0;
	logic signed [15:0] voltUtilIn = '0;
	logic [31:0] paramWdata = '0, rdata, paramRdata;
	logic signed [31:0] actualPosition = '0, positionDelta = '0;
	logic [1:0] paramChannel = '0;
	logic homingDone = '0, absMoveRequest = '0, haltPin = '0, powerStageEnabled = '0;
	logic brakeFitted = 1'h1, capturePin = '0, positionAdjust = '0, err;
	logic [3:0] opState = OPSTATE_SWITCH_ON_DISABLED;
	logic paramAck, paramError, absMoveAllowed, inputControlEnable, commissioningEnable;
	logic haltActive, brakeOpen, brakeReleaseCmd, captureOneCaptured;
	int bad_count = 0, total_checks = 0;
	always #5 clock = ~clock;
	dpcb_param_bank u_dpcb_param_bank (
		.clock(clock),
		.reset(reset),
		.paramReq(paramReq),
		.paramWrite(paramWrite),
		.paramAddr(paramAddr),
		.paramWdata(paramWdata),
		.paramChannel(paramChannel),
		.paramAck(paramAck),
		.paramError(paramError),
		.paramRdata(paramRdata),
		.warnConditions(warnConditions),
		.faultReset(faultReset),
		.voltUtilIn(voltUtilIn),
		.homingDone(homingDone),
		.absMoveRequest(absMoveRequest),
		.absMoveAllowed(absMoveAllowed),
		.inputControlEnable(inputControlEnable),
		.commissioningEnable(commissioningEnable),
		.haltPin(haltPin),
		.haltActive(haltActive),
		.opState(opState),
		.powerStageEnabled(powerStageEnabled),
		.brakeFitted(brakeFitted),
		.brakeOpen(brakeOpen),
		.brakeReleaseCmd(brakeReleaseCmd),
		.capturePin(capturePin),
		.actualPosition(actualPosition),
		.positionAdjust(positionAdjust),
		.positionDelta(positionDelta),
		.captureOneCaptured(captureOneCaptured)
	);
	dpcb_drive_model u_dpcb_drive_model (.clock(clock), .brakeReleaseCmd(brakeReleaseCmd),
		.brakeOpen(brakeOpen));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
		input logic [1:0] ch);
		cyc(1);
		paramReq = 1'h1;
		paramWrite = w;
		paramAddr = a;
		paramWdata = d;
		paramChannel = ch;
		cyc(1);
		paramReq = 1'h0;
		rdata = paramRdata;
		err = paramError;
	endtask : acc
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] ch,
		input logic e);
		acc(1'h1, a, d, ch);
		chk(err, e);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		acc(1'h0, a, 32'h0, CH_FIELDBUS);
		chk(rdata, exp);
	endtask : rd
	// The pin is held long enough to pass the synchroniser and its glitch filter.
	task automatic pin(input logic v);
		capturePin = v;
		cyc(8);
	endtask : pin
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report
	initial begin
		#100000;
		bad_count++;
		final_report();
	end
	initial begin
		cyc(16);
		reset = 1'h0;
		rd(ADDR_USER_MEM3, USER_MEM_RESET);
		rd(ADDR_CAPTURE_INPUT_ONE_EDGE, 32'h0);
		wr(ADDR_USER_MEM4, 32'hA5C3_0F96, CH_FIELDBUS, 1'h0);
		rd(ADDR_USER_MEM4, 32'hA5C3_0F96);
		wr(ADDR_ABS_HOME, 32'h2, CH_FIELDBUS, 1'h1);
		wr(ADDR_CAPTURE_INPUT_ONE_ACT, 32'h3, CH_FIELDBUS, 1'h1);
		wr(ADDR_WARN_ACTIVE, 32'h1, CH_FIELDBUS, 1'h1);
		rd(ADDR_ABS_HOME, 32'h0);
		absMoveRequest = 1'h1;
		cyc(2);
		chk(absMoveAllowed, 1'h1);
		wr(ADDR_ABS_HOME, MAX_FLAG, CH_FIELDBUS, 1'h0);
		cyc(2);
		chk(absMoveAllowed, 1'h0);
		homingDone = 1'h1;
		cyc(2);
		chk(absMoveAllowed, 1'h1);
		wr(ADDR_EXCLUSIVE, 32'h1, CH_FIELDBUS, 1'h0);
		rd(ADDR_EXCLUSIVE, 32'h1);
		wr(ADDR_USER_MEM3, 32'h1, CH_COMMISSIONING, 1'h1);
		wr(ADDR_EXCLUSIVE, 32'h0, CH_FIELDBUS, 1'h0);
		rd(ADDR_EXCLUSIVE, 32'h0);
		wr(ADDR_LOCK, 32'h1, CH_FIELDBUS, 1'h0);
		haltPin = 1'h1;
		cyc(6);
		chk({inputControlEnable, commissioningEnable}, 2'h0);
		chk(haltActive, 1'h1);
		wr(ADDR_USER_MEM3, 32'h7, CH_COMMISSIONING, 1'h1);
		wr(ADDR_LOCK, 32'h0, CH_FIELDBUS, 1'h0);
		cyc(2);
		chk({inputControlEnable, commissioningEnable}, 2'h3);
		wr(ADDR_BRAKE_REL, 32'h1, CH_FIELDBUS, 1'h0);
		cyc(3);
		chk(brakeReleaseCmd, 1'h1);
		rd(ADDR_BRAKE_STATE, 32'h1);
		powerStageEnabled = 1'h1;
		cyc(3);
		rd(ADDR_BRAKE_REL, 32'h0);
		rd(ADDR_BRAKE_STATE, 32'h0);
		powerStageEnabled = 1'h0;
		opState = 4'h8;
		acc(1'h1, ADDR_BRAKE_REL, 32'h1, CH_FIELDBUS);
		cyc(3);
		chk(brakeReleaseCmd, 1'h0);
		brakeFitted = 1'h0;
		cyc(2);
		rd(ADDR_BRAKE_STATE, 32'h2);
		warnConditions = 16'hFFFF;
		cyc(3);
		rd(ADDR_WARN_ACTIVE, 32'h7FF7);
		warnConditions = 16'h0;
		cyc(3);
		rd(ADDR_WARN_ACTIVE, 32'h0);
		rd(ADDR_WARN_LATCHED, 32'h53F7);
		faultReset = 1'h1;
		cyc(1);
		faultReset = 1'h0;
		rd(ADDR_WARN_LATCHED, 32'h0);
		voltUtilIn = 16'hFFFB;
		cyc(2);
		rd(ADDR_VOLT_UTIL, 32'h0000_FFFB);
		actualPosition = 32'h1234_5678;
		wr(ADDR_CAPTURE_INPUT_ONE_EDGE, 32'h1, CH_FIELDBUS, 1'h0);
		wr(ADDR_CAPTURE_INPUT_ONE_ACT, ACT_ONCE, CH_FIELDBUS, 1'h0);
		pin(1'h1);
		chk(captureOneCaptured, 1'h1);
		pin(1'h0);
		actualPosition = 32'h0000_0040;
		pin(1'h1);
		rd(ADDR_CAPTURE_INPUT_ONE_COUNT, 32'h1);
		rd(ADDR_CAPTURE_INPUT_ONE_POS, 32'h1234_5678);
		wr(ADDR_CAPTURE_INPUT_ONE_EDGE, 32'h0, CH_FIELDBUS, 1'h0);
		wr(ADDR_CAPTURE_INPUT_ONE_ACT, ACT_CONTINUOUS, CH_FIELDBUS, 1'h0);
		rd(ADDR_CAPTURE_INPUT_ONE_COUNT, 32'h0);
		chk(captureOneCaptured, 1'h0);
		pin(1'h0);
		actualPosition = 32'hFFFF_FFF0;
		pin(1'h1);
		pin(1'h0);
		rd(ADDR_CAPTURE_INPUT_ONE_COUNT, 32'h2);
		positionDelta = 32'h0000_0020;
		positionAdjust = 1'h1;
		cyc(1);
		positionAdjust = 1'h0;
		rd(ADDR_CAPTURE_INPUT_ONE_POS, 32'h0000_0010);
		wr(ADDR_CAPTURE_INPUT_ONE_ACT, ACT_STOP, CH_FIELDBUS, 1'h0);
		pin(1'h1);
		pin(1'h0);
		rd(ADDR_CAPTURE_INPUT_ONE_COUNT, 32'h2);
		final_report();
	end
endmodule : tb_top
